/* File: hdl/asl_defines.svh */
// Purpose: Constants of the axis standby and limit control block
// Assumes: Parameter numbers are 8 bits, values 32 bits
// Notes: Definitions only
`ifndef ASL_DEFINES_SVH
`define ASL_DEFINES_SVH

// ****************************************
// Parameter numbers
// ****************************************
`define ASL_IDX_IDLE_CURRENT 8'h07
`define ASL_IDX_ARRIVED 8'h08
`define ASL_IDX_HOME_LEVEL 8'h09
`define ASL_IDX_RIGHT_LEVEL 8'h0a
`define ASL_IDX_LEFT_LEVEL 8'h0b
`define ASL_IDX_RIGHT_OFF 8'h0c
`define ASL_IDX_LEFT_OFF 8'h0d
`define ASL_IDX_EXCHANGE 8'h0e
`define ASL_IDX_ACCEL 8'h0f

// ****************************************
// Field widths and reset values
// ****************************************
`define ASL_CURRENT_W 8
`define ASL_ACCEL_W 23
`define ASL_CURRENT_FULL 8'hff
`define ASL_RST_IDLE_CURRENT 8'h00
`define ASL_RST_ACCEL 23'h000001
`define ASL_RST_BIT 1'b0

`endif

/* File: hdl/asl_pkg.sv */
// Purpose: Types of the axis standby and limit control block
// Assumes: Constants come from asl_defines.svh
// Notes: Types only
`include "asl_defines.svh"

package asl_pkg;

    // ****************************************
    // Request and switch carriers
    // ****************************************
    typedef struct packed {
        logic write;
        logic [7:0] index;
        logic [31:0] data;
    } asl_req_t;

    typedef struct packed {
        logic home;
        logic right;
        logic left;
    } asl_sw_t;

    typedef struct packed {
        logic exchange;
        logic right_off;
        logic left_off;
    } asl_sw_cfg_t;

endpackage : asl_pkg

/* File: hdl/asl_switch.sv */
// Purpose: Logical end switch levels and stop requests
// Assumes: Switch inputs already synchronous to clk_sys
// Notes: Purely combinational, registered by the parent
`timescale 1ns/1ns
`default_nettype none

module asl_switch (
    input wire asl_pkg::asl_sw_t pins,
    input wire asl_pkg::asl_sw_cfg_t cfg,
    output var asl_pkg::asl_sw_t level,
    output logic stop_right,
    output logic stop_left
);

    // ****************************************
    // Exchange then gate
    // ****************************************
    always_comb begin
        level.home = pins.home;
        level.right = cfg.exchange ? pins.left : pins.right;
        level.left = cfg.exchange ? pins.right : pins.left;
        stop_right = level.right & ~cfg.right_off;
        stop_left = level.left & ~cfg.left_off;
    end

endmodule : asl_switch

`default_nettype wire

/* File: hdl/asl_ctrl.sv */
// Purpose: Axis standby current, arrival flag and end switch control
// Assumes: Parameter requests arrive one per cycle, answered the next cycle
// Notes: Numbered axis parameters 7 to 15
`timescale 1ns/1ns
`default_nettype none
`include "asl_defines.svh"

module asl_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire asl_pkg::asl_req_t req,
    output logic rsp_valid,
    output logic rsp_error,
    output logic [31:0] rsp_data,
    input wire logic motor_running,
    input wire logic [`ASL_CURRENT_W-1:0] run_current,
    input wire logic [31:0] actual_pos,
    input wire logic [31:0] target_pos,
    input wire asl_pkg::asl_sw_t sw_pins,
    output logic [`ASL_CURRENT_W-1:0] current_set,
    output logic stop_right,
    output logic stop_left,
    output logic [`ASL_ACCEL_W-1:0] first_phase_accel
);

    // One clock domain, so one default clock and reset for all checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // ****************************************
    // State
    // ****************************************
    logic [`ASL_CURRENT_W-1:0] idle_current_level;
    logic target_arrived_flag;
    asl_pkg::asl_sw_t sw_state;
    asl_pkg::asl_sw_cfg_t cfg;
    logic [`ASL_CURRENT_W-1:0] next_idle_current_level;
    logic next_target_arrived_flag;
    asl_pkg::asl_sw_t next_sw_state;
    asl_pkg::asl_sw_cfg_t next_cfg;
    logic [`ASL_ACCEL_W-1:0] next_first_phase_accel;
    logic [`ASL_CURRENT_W-1:0] next_current_set;
    logic next_stop_right;
    logic next_stop_left;
    logic next_rsp_valid;
    logic next_rsp_error;
    logic [31:0] next_rsp_data;
    asl_pkg::asl_sw_t sw_level;
    logic sw_stop_right;
    logic sw_stop_left;

    asl_switch i_asl_switch (
        .pins(sw_pins),
        .cfg(cfg),
        .level(sw_level),
        .stop_right(sw_stop_right),
        .stop_left(sw_stop_left)
    );

    function automatic logic [31:0] asl_bit(input logic b);
        asl_bit = {31'h00000000, b};
    endfunction : asl_bit

    // ****************************************
    // Next values
    // ****************************************
    always_comb begin
        next_idle_current_level = idle_current_level;
        next_cfg = cfg;
        next_first_phase_accel = first_phase_accel;
        next_rsp_valid = req_valid;
        next_rsp_error = 1'b0;
        next_rsp_data = 32'h00000000;
        // Linear code, 0xff is full scale; no lower cap, keeping it low is up to software
        next_current_set = motor_running ? run_current : idle_current_level;
        next_target_arrived_flag = (actual_pos == target_pos);
        next_sw_state = sw_level;
        next_stop_right = sw_stop_right;
        next_stop_left = sw_stop_left;
        if (req_valid) begin
            case (req.index)
                `ASL_IDX_IDLE_CURRENT: begin
                    if (req.write) begin
                        next_idle_current_level = req.data[`ASL_CURRENT_W-1:0];
                    end
                    next_rsp_data = {24'h000000, idle_current_level};
                end
                `ASL_IDX_ARRIVED: begin
                    next_rsp_error = req.write;
                    next_rsp_data = asl_bit(target_arrived_flag);
                end
                `ASL_IDX_HOME_LEVEL: begin
                    next_rsp_error = req.write;
                    next_rsp_data = asl_bit(sw_state.home);
                end
                `ASL_IDX_RIGHT_LEVEL: begin
                    next_rsp_error = req.write;
                    next_rsp_data = asl_bit(sw_state.right);
                end
                `ASL_IDX_LEFT_LEVEL: begin
                    next_rsp_error = req.write;
                    next_rsp_data = asl_bit(sw_state.left);
                end
                `ASL_IDX_RIGHT_OFF: begin
                    if (req.write) begin
                        next_cfg.right_off = req.data[0];
                    end
                    next_rsp_data = asl_bit(cfg.right_off);
                end
                `ASL_IDX_LEFT_OFF: begin
                    if (req.write) begin
                        next_cfg.left_off = req.data[0];
                    end
                    next_rsp_data = asl_bit(cfg.left_off);
                end
                `ASL_IDX_EXCHANGE: begin
                    if (req.write) begin
                        next_cfg.exchange = req.data[0];
                    end
                    next_rsp_data = asl_bit(cfg.exchange);
                end
                `ASL_IDX_ACCEL: begin
                    // Zero is outside the legal range, so it is refused
                    if (req.write && req.data[`ASL_ACCEL_W-1:0] != 23'h000000) begin
                        next_first_phase_accel = req.data[`ASL_ACCEL_W-1:0];
                    end
                    next_rsp_error = req.write && req.data[`ASL_ACCEL_W-1:0] == 23'h000000;
                    next_rsp_data = {9'h000, first_phase_accel};
                end
                default: begin
                    next_rsp_error = 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idle_current_level <= `ASL_RST_IDLE_CURRENT;
            cfg <= '0;
            first_phase_accel <= `ASL_RST_ACCEL;
            target_arrived_flag <= `ASL_RST_BIT;
            sw_state <= '0;
            current_set <= `ASL_RST_IDLE_CURRENT;
            stop_right <= `ASL_RST_BIT;
            stop_left <= `ASL_RST_BIT;
            rsp_valid <= `ASL_RST_BIT;
            rsp_error <= `ASL_RST_BIT;
            rsp_data <= 32'h00000000;
        end else begin
            idle_current_level <= next_idle_current_level;
            cfg <= next_cfg;
            first_phase_accel <= next_first_phase_accel;
            target_arrived_flag <= next_target_arrived_flag;
            sw_state <= next_sw_state;
            current_set <= next_current_set;
            stop_right <= next_stop_right;
            stop_left <= next_stop_left;
            rsp_valid <= next_rsp_valid;
            rsp_error <= next_rsp_error;
            rsp_data <= next_rsp_data;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_wr_idle;
        req_valid && req.write && req.index == `ASL_IDX_IDLE_CURRENT;
    endsequence

    sequence s_wr_flag;
        req_valid && req.write && req.index == `ASL_IDX_ARRIVED;
    endsequence

    a_idle_current: assert property (!motor_running |=> current_set == $past(idle_current_level))
        else $error("Idle motor not at idle current");
    a_run_current: assert property (motor_running |=> current_set == $past(run_current))
        else $error("Running motor not at run current");
    a_idle_write: assert property (s_wr_idle |=> idle_current_level == $past(req.data[7:0])
        && rsp_valid && !rsp_error)
        else $error("Idle current write lost");
    a_right_off: assert property (cfg.right_off |=> !stop_right)
        else $error("Disabled right switch still stops");
    a_right_on: assert property (!cfg.right_off && sw_level.right |=> stop_right)
        else $error("Right switch failed to stop");
    a_left_off: assert property (cfg.left_off |=> !stop_left)
        else $error("Disabled left switch still stops");
    a_left_on: assert property (!cfg.left_off && sw_level.left |=> stop_left)
        else $error("Left switch failed to stop");
    a_arrived_eq: assert property (actual_pos == target_pos |=> target_arrived_flag)
        else $error("Arrival flag low at equal positions");
    a_arrived_ne: assert property (actual_pos != target_pos |=> !target_arrived_flag)
        else $error("Arrival flag high at unequal positions");
    a_flag_ro: assert property (s_wr_flag |=> rsp_valid && rsp_error
        ##0 target_arrived_flag == $past(actual_pos == target_pos))
        else $error("Arrival flag write not refused");

endmodule : asl_ctrl

`default_nettype wire

/* File: sim/asl_partner.sv */
// Purpose: Far side model, motor driver and home and end switches
// Assumes: Bench sets wanted levels just after a clock edge
// Notes: An end stop halts the motor as a real driver would
`timescale 1ns/1ns
`default_nettype none

module asl_partner (
    input wire logic run_want,
    input wire asl_pkg::asl_sw_t sw_want,
    input wire logic stop_right,
    input wire logic stop_left,
    output logic motor_running,
    output var asl_pkg::asl_sw_t sw_pins
);
    // Stop requests end a move at once, no coasting modelled
    assign motor_running = run_want & ~stop_right & ~stop_left;
    assign sw_pins = sw_want;
endmodule : asl_partner

`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench of the axis standby and limit control
// Assumes: One request per op call, answers checked at the falling edge
// Notes: Expected answers queued by the driver, popped by the monitor
`timescale 1ns/1ns
`default_nettype none
`include "asl_defines.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module tb_top;
    logic clk_sys = 1'b0;
    logic rst_n, req_valid, run_want, rsp_valid, rsp_error, stop_right, stop_left, motor_running;
    logic roff = 1'b0, loff = 1'b0, exch = 1'b0, lr, ll;
    logic [7:0] run_current, current_set;
    logic [31:0] rsp_data, actual_pos, target_pos, r;
    logic [22:0] first_phase_accel;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [32:0] got;
    asl_pkg::asl_req_t req;
    asl_pkg::asl_sw_t sw_want, sw_pins;
    int failures = 0;
    int tests_run = 0;

    asl_ctrl i_asl_ctrl (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_data(rsp_data),
        .motor_running(motor_running), .run_current(run_current), .actual_pos(actual_pos),
        .target_pos(target_pos), .sw_pins(sw_pins), .current_set(current_set),
        .stop_right(stop_right), .stop_left(stop_left), .first_phase_accel(first_phase_accel));
    asl_partner i_asl_partner (.run_want(run_want), .sw_want(sw_want), .stop_right(stop_right),
        .stop_left(stop_left), .motor_running(motor_running), .sw_pins(sw_pins));

    always #20 clk_sys = ~clk_sys;

    // Bit 33 set means the answer data is not compared
    task op(input logic w, input logic [7:0] idx, input logic [31:0] d, input logic err,
            input logic [32:0] x);
        req_valid = 1'b1;
        req = '{write: w, index: idx, data: d};
        exp_q.push_back({x[32], err, x[31:0]});
        @(posedge clk_sys);
        #1;
    endtask : op

    task gap(input int n);
        req_valid = 1'b0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : gap

    task conclude;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : conclude

    always @(negedge clk_sys) begin
        if (rsp_valid === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : {2'b00, 32'hdead_0000};
            // Built first, so no brace with commas goes through the macro
            got = {rsp_error, e[33] ? e[31:0] : rsp_data};
            `CHK(got, e[32:0])
        end
    end

    initial begin
        #100000;
        failures++;
        conclude();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin : main
        int k;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        run_want = 1'b0;
        sw_want = '0;
        run_current = 8'h80;
        actual_pos = 32'h0;
        target_pos = 32'h0;
        void'($urandom(32'hc665));
        repeat (2) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        op(0, `ASL_IDX_IDLE_CURRENT, 0, 0, 0);
        op(0, `ASL_IDX_ACCEL, 0, 0, 1);
        for (k = 12; k < 15; k++) op(0, 8'(k), 0, 0, 0);
        r = $urandom();
        op(1, `ASL_IDX_IDLE_CURRENT, r, 0, 0);
        op(1, `ASL_IDX_IDLE_CURRENT, 32'h1ff, 0, {25'h0, r[7:0]});
        op(0, `ASL_IDX_IDLE_CURRENT, 0, 0, `ASL_CURRENT_FULL);
        op(1, `ASL_IDX_IDLE_CURRENT, 32'h10, 0, `ASL_CURRENT_FULL);
        gap(3);
        `CHK(current_set, 8'h10)
        run_want = 1'b1;
        gap(3);
        `CHK(current_set, run_current)
        run_want = 1'b0;
        gap(3);
        `CHK(current_set, 8'h10)
        for (k = 8; k < 12; k++) op(1, 8'(k), 1, 1, 33'h1_0000_0000);
        op(0, 8'h10, 0, 1, 0);
        op(1, `ASL_IDX_ACCEL, 0, 1, 33'h1_0000_0000);
        op(1, `ASL_IDX_ACCEL, r | 1, 0, 1);
        gap(2);
        `CHK(first_phase_accel, 23'(r | 1))
        actual_pos = r;
        target_pos = r;
        gap(3);
        op(0, `ASL_IDX_ARRIVED, 0, 0, 1);
        actual_pos = r + 1;
        gap(3);
        op(0, `ASL_IDX_ARRIVED, 0, 0, 0);
        for (k = 0; k < 8; k++) begin
            op(1, `ASL_IDX_EXCHANGE, k[2], 0, exch);
            op(1, `ASL_IDX_RIGHT_OFF, k[1], 0, roff);
            op(1, `ASL_IDX_LEFT_OFF, k[0], 0, loff);
            {exch, roff, loff} = k[2:0];
            sw_want = 3'($urandom());
            gap(3);
            lr = exch ? sw_want.left : sw_want.right;
            ll = exch ? sw_want.right : sw_want.left;
            `CHK(stop_right, lr & ~roff)
            `CHK(stop_left, ll & ~loff)
            op(0, `ASL_IDX_RIGHT_LEVEL, 0, 0, lr);
            op(0, `ASL_IDX_LEFT_LEVEL, 0, 0, ll);
            op(0, `ASL_IDX_HOME_LEVEL, 0, 0, sw_want.home);
        end
        gap(4);
        // Mid-run reset must bring back the reset values
        rst_n = 1'b0;
        gap(2);
        rst_n = 1'b1;
        op(0, `ASL_IDX_IDLE_CURRENT, 0, 0, 0);
        op(0, `ASL_IDX_EXCHANGE, 0, 0, 0);
        gap(4);
        // Every queued answer must have come back
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule : tb_top

`default_nettype wire
